// [logic/eebac_ctrl.v]
// eebac_ctrl.v: byte-wide non-volatile store with location, byte and
// control registers on the special function register port.
// assumes the core presents the effective address of each access, so
// indirect pointer handling lives in the core, not here.
`timescale 1ns/1ps
`include "eebac_regs.vh"

module eebac_ctrl #(
    parameter WRITE_CYCLES = `EEBAC_WRITE_CYCLES
) (
    input wire CLOCK_I,
    input wire RSTN_I,
    input wire [6:0] SFR_ADDR_I,
    input wire SFR_WR_I,
    input wire SFR_RD_I,
    input wire [7:0] SFR_WDATA_I,
    input wire GLOBAL_IRQ_ENABLE_I,
    input wire IRQ_ACK_I,
    output reg [7:0] SFR_RDATA_O,
    output reg BANK_SELECT_O,
    output reg NV_IRQ_FLAG_O,
    output reg MF_REQ_O,
    output reg IRQ_O,
    output reg BUSY_O
);

    // ======================================================
    // state encoding
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_READ = 3'b010;
    localparam [2:0] ST_WRITE = 3'b100;
    localparam integer READ_LAST_N = `EEBAC_READ_CYCLES - 1;
    localparam [3:0] READ_LAST = READ_LAST_N[3:0];

    // ======================================================
    // address decode
    // control register lives only in bank 1; the rest are common
    function hit;
        input [6:0] addr;
        input [6:0] offset;
        input need_bank;
        input bank;
        begin
            hit = (addr == offset) && (!need_bank || bank);
        end
    endfunction

    // ======================================================
    // storage
    // cells carry no reset: contents survive a reset as they would
    // survive a power cycle
    reg [7:0] store [0:`EEBAC_DEPTH-1];

    reg [5:0] nv_location;
    reg [7:0] nv_byte;
    reg store_permit;
    reg store_go;
    reg read_permit;
    reg read_go;
    reg bank_select;
    reg nv_irq_enable;
    reg mf_irq_enable;
    reg nv_irq_flag;
    reg mf_flag;
    reg [2:0] state;
    reg [5:0] cycle_loc;
    reg [7:0] cycle_byte;
    reg [3:0] read_count;

    reg [2:0] next_state;
    reg [7:0] next_rdata;

    wire wr_bank;
    wire wr_loc;
    wire wr_byte;
    wire wr_irq;
    wire wr_ctrl;
    wire rd_ctrl;
    wire idle;
    wire accept_store;
    wire accept_read;
    wire store_done;
    wire read_done;
    wire next_nv_flag;
    wire next_mf_flag;

    assign wr_bank = SFR_WR_I &&
        hit(SFR_ADDR_I, `EEBAC_OFF_BANK, 1'b0, bank_select);
    assign wr_loc = SFR_WR_I &&
        hit(SFR_ADDR_I, `EEBAC_OFF_LOC, 1'b0, bank_select);
    assign wr_byte = SFR_WR_I &&
        hit(SFR_ADDR_I, `EEBAC_OFF_BYTE, 1'b0, bank_select);
    assign wr_irq = SFR_WR_I &&
        hit(SFR_ADDR_I, `EEBAC_OFF_IRQ, 1'b0, bank_select);
    assign wr_ctrl = SFR_WR_I &&
        hit(SFR_ADDR_I, `EEBAC_OFF_CTRL, `EEBAC_CTRL_BANK, bank_select);
    assign rd_ctrl =
        hit(SFR_ADDR_I, `EEBAC_OFF_CTRL, `EEBAC_CTRL_BANK, bank_select);

    // ======================================================
    // request acceptance
    assign idle = (state == ST_IDLE);

    // go only counts when the permit was set before this write and
    // stays set by it; a write asking for both goes takes the store
    assign accept_store = wr_ctrl && idle &&
        SFR_WDATA_I[`EEBAC_STORE_GO] &&
        store_permit &&
        SFR_WDATA_I[`EEBAC_STORE_PERMIT];
    assign accept_read = wr_ctrl && idle && !accept_store &&
        SFR_WDATA_I[`EEBAC_READ_GO] &&
        read_permit &&
        SFR_WDATA_I[`EEBAC_READ_PERMIT];

    // ======================================================
    // write timer
    eebac_timer #(
        .CYCLES(WRITE_CYCLES)
    ) u_timer (
        .clock_i(CLOCK_I),
        .rstn_i(RSTN_I),
        .start_i(accept_store),
        .done_o(store_done)
    );

    assign read_done = (state == ST_READ) && (read_count == READ_LAST);

    // ======================================================
    // sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept_store) begin
                    next_state = ST_WRITE;
                end else if (accept_read) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (read_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (store_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            state <= ST_IDLE;
            read_count <= 4'h0;
        end else begin
            state <= next_state;
            if (state == ST_READ) begin
                read_count <= read_count + 4'h1;
            end else begin
                read_count <= 4'h0;
            end
        end
    end

    // ======================================================
    // cycle latches
    always @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            cycle_loc <= `EEBAC_RST_LOC;
            cycle_byte <= `EEBAC_RST_BYTE;
        end else if (accept_store || accept_read) begin
            cycle_loc <= nv_location;
            cycle_byte <= nv_byte;
        end
    end

    // ======================================================
    // store array
    // a permit dropped mid-cycle still cancels the commit
    always @(posedge CLOCK_I) begin
        if (store_done && store_permit) begin
            store[cycle_loc] <= cycle_byte;
        end
    end

    // ======================================================
    // location, byte and bank registers
    always @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            nv_location <= `EEBAC_RST_LOC;
            nv_byte <= `EEBAC_RST_BYTE;
            bank_select <= `EEBAC_RST_BANK;
        end else begin
            if (wr_loc) begin
                nv_location <= SFR_WDATA_I[5:0];
            end
            if (read_done && read_permit) begin
                nv_byte <= store[cycle_loc];
            end else if (wr_byte) begin
                nv_byte <= SFR_WDATA_I;
            end
            if (wr_bank) begin
                bank_select <= SFR_WDATA_I[0];
            end
        end
    end

    // ======================================================
    // control register
    // go bits are set by software and cleared only by hardware
    always @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            store_permit <= 1'b0;
            read_permit <= 1'b0;
            store_go <= 1'b0;
            read_go <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                store_permit <= SFR_WDATA_I[`EEBAC_STORE_PERMIT];
                read_permit <= SFR_WDATA_I[`EEBAC_READ_PERMIT];
            end
            if (accept_store) begin
                store_go <= 1'b1;
            end else if (store_done) begin
                store_go <= 1'b0;
            end
            if (accept_read) begin
                read_go <= 1'b1;
            end else if (read_done) begin
                read_go <= 1'b0;
            end
        end
    end

    // ======================================================
    // completion flags
    // set beats a same-cycle clear by software or by service
    assign next_nv_flag = store_done ||
        (wr_irq ? SFR_WDATA_I[`EEBAC_IRQ_NV_FLAG] : nv_irq_flag);
    assign next_mf_flag = store_done ||
        (wr_irq ? SFR_WDATA_I[`EEBAC_IRQ_MF_FLAG] :
        (mf_flag && !IRQ_ACK_I));

    always @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            nv_irq_enable <= 1'b0;
            mf_irq_enable <= 1'b0;
            nv_irq_flag <= 1'b0;
            mf_flag <= 1'b0;
        end else begin
            if (wr_irq) begin
                nv_irq_enable <= SFR_WDATA_I[`EEBAC_IRQ_NV_EN];
                mf_irq_enable <= SFR_WDATA_I[`EEBAC_IRQ_MF_EN];
            end
            nv_irq_flag <= next_nv_flag;
            mf_flag <= next_mf_flag;
        end
    end

    // ======================================================
    // read-back
    // unimplemented bits and unmapped addresses read as zero
    always @* begin
        next_rdata = 8'h00;
        if (hit(SFR_ADDR_I, `EEBAC_OFF_LOC, 1'b0, bank_select)) begin
            next_rdata = {2'b00, nv_location};
        end else if (hit(SFR_ADDR_I, `EEBAC_OFF_BYTE, 1'b0,
                bank_select)) begin
            next_rdata = nv_byte;
        end else if (hit(SFR_ADDR_I, `EEBAC_OFF_BANK, 1'b0,
                bank_select)) begin
            next_rdata = {7'h00, bank_select};
        end else if (hit(SFR_ADDR_I, `EEBAC_OFF_IRQ, 1'b0,
                bank_select)) begin
            next_rdata = {4'h0, mf_flag, nv_irq_flag,
                mf_irq_enable, nv_irq_enable};
        end else if (rd_ctrl) begin
            next_rdata = {4'h0, store_permit, store_go,
                read_permit, read_go};
        end
    end

    // ======================================================
    // registered outputs
    always @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            SFR_RDATA_O <= 8'h00;
            BANK_SELECT_O <= `EEBAC_RST_BANK;
            NV_IRQ_FLAG_O <= 1'b0;
            MF_REQ_O <= 1'b0;
            IRQ_O <= 1'b0;
            BUSY_O <= 1'b0;
        end else begin
            if (SFR_RD_I) begin
                SFR_RDATA_O <= next_rdata;
            end
            BANK_SELECT_O <= next_bank_value(wr_bank, SFR_WDATA_I[0],
                bank_select);
            NV_IRQ_FLAG_O <= next_nv_flag;
            MF_REQ_O <= next_mf_flag;
            IRQ_O <= GLOBAL_IRQ_ENABLE_I && nv_irq_enable &&
                mf_irq_enable && next_nv_flag &&
                next_mf_flag;
            BUSY_O <= (next_state != ST_IDLE);
        end
    end

    // mirrors the bank register so the output tracks it exactly
    function next_bank_value;
        input write;
        input value;
        input current;
        begin
            next_bank_value = write ? value : current;
        end
    endfunction

endmodule // eebac_ctrl

// [logic/eebac_regs.vh]
// eebac_regs.vh: offsets, field positions, reset values and timing
// counts for the byte-wide non-volatile store controller.
// assumes the includer sets `timescale and runs at a 10 MHz clock.
//
// Summary of operation
// - store holds 64 bytes, 6-bit index
// - each access moves one byte via registers
// - location bits 5..0, upper two read zero
// - control bits 3..0 permit/go, upper read zero
// - no store write while store_permit is zero
// - store_go starts write, hardware clears at end
// - store_go ignored unless store_permit already set
// - no store read while read_permit is zero
// - read_go starts read, clears, byte then readable
// - read_go ignored unless read_permit already set
// - fetched byte stays until next read or write
// - write length from internal timer; completion visible
// - power-on clears store_permit and bank_select
// - write end sets flag pair; interrupt needs enables
// - service clears only multi-function flag
// - power-up clears bank_select
`ifndef EEBAC_REGS_VH
`define EEBAC_REGS_VH

// ==========================================================
// register offsets (7-bit special function address space)
`define EEBAC_OFF_BANK 7'h04
`define EEBAC_OFF_LOC 7'h2a
`define EEBAC_OFF_BYTE 7'h2b
`define EEBAC_OFF_IRQ 7'h2c
`define EEBAC_OFF_CTRL 7'h40
`define EEBAC_CTRL_BANK 1'b1

// ==========================================================
// field positions
`define EEBAC_READ_GO 0
`define EEBAC_READ_PERMIT 1
`define EEBAC_STORE_GO 2
`define EEBAC_STORE_PERMIT 3
`define EEBAC_IRQ_NV_EN 0
`define EEBAC_IRQ_MF_EN 1
`define EEBAC_IRQ_NV_FLAG 2
`define EEBAC_IRQ_MF_FLAG 3

// ==========================================================
// store geometry and reset values
`define EEBAC_DEPTH 64
`define EEBAC_AW 6
`define EEBAC_RST_LOC 6'h00
`define EEBAC_RST_BYTE 8'h00
`define EEBAC_RST_BANK 1'b0

// ==========================================================
// timing
`define EEBAC_CLK_KHZ 10000
`define EEBAC_WRITE_TIME_US 2000
`define EEBAC_WRITE_CYCLES \
    ((`EEBAC_WRITE_TIME_US * `EEBAC_CLK_KHZ + 999) / 1000)
`define EEBAC_READ_TIME_NS 200
`define EEBAC_READ_CYCLES \
    ((`EEBAC_READ_TIME_NS * `EEBAC_CLK_KHZ + 999999) / 1000000)

`endif

// [logic/eebac_timer.v]
// eebac_timer.v: one-shot write timer for the non-volatile store.
// assumes start is a single-cycle pulse given only while idle.
`timescale 1ns/1ps
`include "eebac_regs.vh"

module eebac_timer #(
    parameter CYCLES = `EEBAC_WRITE_CYCLES
) (
    input wire clock_i,
    input wire rstn_i,
    input wire start_i,
    output reg done_o
);

    // ======================================================
    // countdown
    // stands in for the free-running cell timer; one clock only, so
    // its length is a cycle count rather than a separate oscillator
    localparam integer LAST_N = CYCLES - 1;
    localparam [19:0] LAST = LAST_N[19:0];
    reg [19:0] count;
    reg running;

    always @(posedge clock_i) begin
        if (!rstn_i) begin
            count <= 20'h00000;
            running <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !running) begin
                count <= 20'h00000;
                running <= 1'b1;
            end else if (running) begin
                if (count == LAST) begin
                    running <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count <= count + 20'h00001;
                end
            end
        end
    end

endmodule // eebac_timer

// [tb/eebac_core_model.sv]
// eebac_core_model.sv: core side of the register port, one byte a call.
// assumes a free-running clock; drives at falling edges only.
`timescale 1ns/1ps
module eebac_core_model (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output logic [6:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    initial begin
        addr_o = 7'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // released lines are inverted so stale values cannot pass for live ones
    task automatic put(input logic [6:0] a, input logic [7:0] d);
        @(negedge clock_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clock_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic get(input logic [6:0] a, output logic [7:0] d);
        @(negedge clock_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clock_i);
        rd_o = 1'b0;
        addr_o = ~a;
        @(negedge clock_i);
        d = rdata_i;
    endtask
    task automatic store_byte(input logic [5:0] loc, input logic [7:0] d);
        put(7'h2a, {2'b00, loc});
        put(7'h2b, d);
        put(7'h04, 8'h01);
        put(7'h40, 8'h08);
        put(7'h40, 8'h0c);
    endtask
    task automatic fetch_start(input logic [5:0] loc);
        put(7'h04, 8'h01);
        put(7'h40, 8'h02);
        put(7'h2a, {2'b00, loc});
        put(7'h40, 8'h03);
    endtask
endmodule // eebac_core_model

// [tb/eebac_ctrl_assertions.sv]
// eebac_ctrl_assertions.sv: port-level checks of the store controller.
// assumes it is bound into eebac_ctrl and given the same write length.
`timescale 1ns/1ps
module eebac_ctrl_assertions #(
    parameter int WRITE_CYCLES = 8
) (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic [6:0] SFR_ADDR_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic GLOBAL_IRQ_ENABLE_I,
    input wire logic IRQ_ACK_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic BANK_SELECT_O,
    input wire logic NV_IRQ_FLAG_O,
    input wire logic MF_REQ_O,
    input wire logic IRQ_O,
    input wire logic BUSY_O
);
    // ====================
    // helper state
    logic permit_w;
    logic wr_run;
    logic [15:0] cnt;
    wire ctrl_wr = SFR_WR_I && SFR_ADDR_I == 7'h40 && BANK_SELECT_O;
    wire store_req = ctrl_wr && SFR_WDATA_I[3:2] == 2'b11 && permit_w
        && !BUSY_O;
    // cnt is 16 bits so the full-length write still fits
    always @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            permit_w <= 1'b0;
            wr_run <= 1'b0;
            cnt <= 16'h0000;
        end else begin
            if (ctrl_wr)
                permit_w <= SFR_WDATA_I[3];
            if (store_req)
                wr_run <= 1'b1;
            else if (!BUSY_O)
                wr_run <= 1'b0;
            cnt <= BUSY_O ? cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    // ====================
    // write cycle steps
    sequence s_store_req;
        store_req;
    endsequence
    sequence s_write_run;
        BUSY_O [*8];
    endsequence
    sequence s_write_end;
        $fell(BUSY_O) && wr_run;
    endsequence
    // ====================
    // properties
    a_reset_quiet: assert property ($rose(RSTN_I) |-> !BUSY_O && !IRQ_O
        && !BANK_SELECT_O && SFR_RDATA_O == 8'h00) else $error("reset state");
    a_bank_set: assert property (SFR_WR_I && SFR_ADDR_I == 7'h04
        && SFR_WDATA_I[0] |=> BANK_SELECT_O) else $error("bank not set");
    a_loc_upper: assert property (SFR_RD_I && SFR_ADDR_I == 7'h2a
        |=> SFR_RDATA_O[7:6] == 2'b00) else $error("location upper bits");
    a_ctrl_upper: assert property (SFR_RD_I && SFR_ADDR_I == 7'h40
        |=> SFR_RDATA_O[7:4] == 4'h0) else $error("control upper bits");
    a_ctrl_hidden: assert property (SFR_RD_I && SFR_ADDR_I == 7'h40
        && !BANK_SELECT_O |=> SFR_RDATA_O == 8'h00) else $error("bank 0");
    a_go_gated: assert property (ctrl_wr && !BUSY_O
        && (SFR_WDATA_I & 8'h0a) == 8'h00 |=> !BUSY_O) else $error("no permit");
    a_write_holds: assert property (s_store_req |=> s_write_run)
        else $error("write cycle short");
    a_write_len: assert property (s_write_end |-> cnt >= WRITE_CYCLES
        && cnt <= WRITE_CYCLES + 2) else $error("write length");
    a_write_flags: assert property (s_write_end
        |-> NV_IRQ_FLAG_O && MF_REQ_O) else $error("write flags");
    a_read_len: assert property ($fell(BUSY_O) && !wr_run |-> cnt <= 3)
        else $error("read length");
    a_irq_cause: assert property ($rose(IRQ_O)
        |-> NV_IRQ_FLAG_O && MF_REQ_O) else $error("irq without flags");
    a_ack_clears: assert property (IRQ_ACK_I && NV_IRQ_FLAG_O && !BUSY_O
        && !SFR_WR_I |=> !MF_REQ_O && NV_IRQ_FLAG_O) else $error("ack");
    a_rdata_holds: assert property (!SFR_RD_I && !$past(SFR_RD_I)
        |=> $stable(SFR_RDATA_O)) else $error("read data moved");
endmodule // eebac_ctrl_assertions

// [tb/eebac_ctrl_tb.sv]
// eebac_ctrl_tb.sv: self-checking bench for the store controller.
// assumes a short write length of 8 cycles to keep the run brief.
`timescale 1ns/1ps
module eebac_ctrl_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic glob = 1'b0;
    logic ack = 1'b0;
    wire [6:0] addr;
    wire wr;
    wire rd;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire bank;
    wire nv_flag;
    wire mf;
    wire irq;
    wire busy;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] mem [64];
    logic [5:0] locs [8];
    logic [7:0] v;
    always #50 clk = ~clk;
    eebac_core_model core (.clock_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    eebac_ctrl #(.WRITE_CYCLES(8)) dut (.CLOCK_I(clk), .RSTN_I(rstn),
        .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
        .GLOBAL_IRQ_ENABLE_I(glob), .IRQ_ACK_I(ack), .SFR_RDATA_O(rdata),
        .BANK_SELECT_O(bank), .NV_IRQ_FLAG_O(nv_flag), .MF_REQ_O(mf),
        .IRQ_O(irq), .BUSY_O(busy));
    // ====================
    // checking and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // control register image from its four bits, upper bits always zero
    function automatic logic [7:0] ctrl_exp(input logic sp, input logic sg,
            input logic rp, input logic rg);
        return {4'h0, sp, sg, rp, rg};
    endfunction
    task automatic expect_reg(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        core.get(a, d);
        check(d, exp);
    endtask
    task automatic wait_idle();
        @(negedge clk);
        for (int i = 0; i < 40 && busy !== 1'b0; i++)
            @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ceiling well above the ~460 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ====================
    // main sequence
    initial begin
        void'($urandom(32'h93be849e));
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        expect_reg(7'h2b, 8'h00);
        expect_reg(7'h40, 8'h00);
        expect_reg(7'h10, 8'h00);
        check({7'h00, bank}, 8'h00);
        core.put(7'h2a, 8'hff);
        expect_reg(7'h2a, 8'h3f);
        core.put(7'h04, 8'h01);
        // permit and go in one write: a fresh permit must not count
        core.put(7'h40, 8'h0c);
        check({7'h00, busy}, 8'h00);
        expect_reg(7'h40, ctrl_exp(1'b1, 1'b0, 1'b0, 1'b0));
        core.put(7'h40, 8'h03);
        expect_reg(7'h40, ctrl_exp(1'b0, 1'b0, 1'b1, 1'b0));
        core.put(7'h40, 8'hf2);
        expect_reg(7'h40, 8'h02);
        core.put(7'h2c, 8'h03);
        for (int i = 0; i < 8; i++) begin
            locs[i] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
            v = 8'($urandom);
            mem[locs[i]] = v;
            glob = 1'b0;
            core.store_byte(locs[i], v);
            glob = i[0];
            // moving location and byte mid-write must not redirect it
            core.put(7'h2a, {2'b00, ~locs[i]});
            core.put(7'h2b, ~v);
            // read permit first, so only the running write can refuse it
            core.put(7'h40, 8'h0a);
            core.put(7'h40, 8'h0b);
            wait_idle();
            check({7'h00, busy}, 8'h00);
            check({6'h00, nv_flag, mf}, 8'h03);
            check({7'h00, irq}, {7'h00, glob});
            expect_reg(7'h40, 8'h0a);
            ack = 1'b1;
            @(negedge clk);
            ack = 1'b0;
            @(negedge clk);
            check({6'h00, nv_flag, mf}, 8'h02);
            core.put(7'h2c, 8'h03);
            check({6'h00, nv_flag, mf}, 8'h00);
            core.put(7'h40, 8'h00);
            core.put(7'h04, 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            core.fetch_start(locs[i]);
            wait_idle();
            expect_reg(7'h40, 8'h02);
            expect_reg(7'h2b, mem[locs[i]]);
            core.put(7'h2a, 8'h15);
            expect_reg(7'h2b, mem[locs[i]]);
        end
        end_of_test();
    end
endmodule // eebac_ctrl_tb

bind eebac_ctrl eebac_ctrl_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I), .SFR_WDATA_I(SFR_WDATA_I),
    .GLOBAL_IRQ_ENABLE_I(GLOBAL_IRQ_ENABLE_I), .IRQ_ACK_I(IRQ_ACK_I),
    .SFR_RDATA_O(SFR_RDATA_O), .BANK_SELECT_O(BANK_SELECT_O),
    .NV_IRQ_FLAG_O(NV_IRQ_FLAG_O), .MF_REQ_O(MF_REQ_O), .IRQ_O(IRQ_O),
    .BUSY_O(BUSY_O));
